// ---- shared/drt_cfg.svh ----
// Purpose: Constants for the dual reload down timer
// Assumes: AXI4-Lite, 32-bit data, one word per register
// Notes:   Offsets are byte addresses
`ifndef DRT_CFG_SVH
`define DRT_CFG_SVH
`define DRT_OFF_CTRL     4'h0
`define DRT_OFF_CFG0     4'h4
`define DRT_OFF_CFG1     4'h8
`define DRT_OFF_STAT     4'hc
`define DRT_CTL_RUN0     0
`define DRT_CTL_RUN1     1
`define DRT_CTL_PRESET_CH0    2
`define DRT_CTL_PRESET_CH1    3
`define DRT_CTL_WIDTH    4
`define DRT_CFG_CONT     0
`define DRT_CFG_SRC      1
`define DRT_CFG_DIV_LO   2
`define DRT_CFG_RLD_LO   8
`define DRT_RESET_BYTE   8'h00
`define DRT_RESP_OKAY    2'b00
`define DRT_RESP_SLVERR  2'b10
`endif

// ---- shared/drt_pkg.sv ----
// Purpose: Types for the dual reload down timer
// Assumes: Nothing beyond the cfg header
// Notes:   Div codes select 1, 4, 16, 64
package drt_pkg;
  typedef enum logic [1:0] {
    DRT_DIV1  = 2'b00,
    DRT_DIV4  = 2'b01,
    DRT_DIV16 = 2'b10,
    DRT_DIV64 = 2'b11
  } drt_div_t;
  typedef enum logic [2:0] {
    DRT_W_IDLE = 3'b001,
    DRT_W_RESP = 3'b010,
    DRT_W_HOLD = 3'b100
  } drt_wstate_t;
endpackage

// ---- logic/drt_sync.sv ----
// Purpose: Two-flop synchroniser for the oscillator inputs
// Assumes: Inputs are asynchronous to aclk
// Notes:   First stage is read only by the second
`timescale 1ns/100ps
`default_nettype none
module drt_sync
  import drt_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic d,
  output logic      q
);
  logic meta_r;

  // Two stages, only the second reads the first
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_r <= 1'b0;
      q      <= 1'b0;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ---- logic/drt_prescaler.sv ----
// Purpose: Per-channel prescaler, edges of the divided input clock
// Assumes: src is synchronised, rise and fall edge pulses from the top
// Notes:   Gated by run; divider held cleared while stopped
`timescale 1ns/100ps
`default_nettype none
module drt_prescaler
  import drt_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       run,
  input  wire logic       src_rise,
  input  wire logic       src_fall,
  input  wire logic [1:0] div,
  output logic            in_fall,
  output logic            in_rise
);
  logic [5:0] cnt_r;
  logic [5:0] mask;

  // Mask of the divider bits used by the selected ratio
  always_comb
  begin
    unique case (drt_div_t'(div))
      DRT_DIV1:  mask = 6'h00;
      DRT_DIV4:  mask = 6'h03;
      DRT_DIV16: mask = 6'h0f;
      DRT_DIV64: mask = 6'h3f;
    endcase
  end

  // Source reaches the divider only while running
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !run)
      cnt_r <= 6'h00;
    else if (src_rise)
      cnt_r <= (cnt_r + 6'h01) & mask;
  end

  // Divided clock: falls when divider at half its range sees a source fall
  always_comb
  begin
    in_fall = run && src_fall && ((cnt_r & mask) == (mask >> 1) + 6'h01 - 6'h01 + 6'h00)
              && (mask == 6'h00 || cnt_r == (mask >> 1));
    in_rise = run && src_rise && ((cnt_r & mask) == mask);
  end
endmodule
`default_nettype wire

// ---- logic/drt_top.sv ----
// Purpose: Two 8-bit reload down timers, cascadable to 16 bits, AXI4-Lite slave
// Assumes: slow_osc and fast_osc are asynchronous square waves, slower than aclk/4
// Notes:   Register map and bit positions live in the cfg header
//
// Added by the designer: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "drt_cfg.svh"
module drt_top
  import drt_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        slow_osc,
  input  wire logic        fast_osc,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             underflow_flag_ch0,
  output logic             underflow_flag_ch1,
  output logic             halved_underflow_out,
  output logic             serial_clk_pulse
);
  logic       slow_s;
  logic       fast_s;
  logic       slow_d_r;
  logic       fast_d_r;
  logic       width_mode_sel_r;
  logic [1:0] run_r;
  logic [1:0] repeat_r;
  logic [1:0] src_sel_r;
  logic [1:0] div_r [2];
  logic [7:0] reload_r [2];
  logic [7:0] count_r [2];
  logic [1:0] pend_r;
  logic [1:0] in_fall;
  logic [1:0] in_rise;
  logic [1:0] unf;
  logic       uf16;
  logic [1:0] pset_wr;
  logic       wr_go;
  logic       ctrl_wr;
  logic [1:0] cfg_wr;
  logic [31:0] rd_nxt;
  logic        rd_ok;
  logic [31:0] wdata_r;
  logic [3:0]  awaddr_r;
  logic        aw_have_r;
  logic        w_have_r;
  logic        wstrb_ok_r;

  // Oscillator inputs cross into aclk
  drt_sync u_sync_slow (.aclk(aclk), .aresetn(aresetn), .d(slow_osc), .q(slow_s));
  drt_sync u_sync_fast (.aclk(aclk), .aresetn(aresetn), .d(fast_osc), .q(fast_s));

  // Previous synchronised levels for edge detection
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      slow_d_r <= 1'b0;
      fast_d_r <= 1'b0;
    end
    else
    begin
      slow_d_r <= slow_s;
      fast_d_r <= fast_s;
    end
  end

  // Prescaler per channel; in 16-bit mode both follow channel 0
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_ch
      logic       sel;
      logic [1:0] dv;
      logic       rn;
      assign sel = width_mode_sel_r ? src_sel_r[0] : src_sel_r[g];
      assign dv  = width_mode_sel_r ? div_r[0] : div_r[g];
      assign rn  = width_mode_sel_r ? run_r[0] : run_r[g];
      drt_prescaler u_psc (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .run      (rn),
        .src_rise (sel ? (fast_s & ~fast_d_r) : (slow_s & ~slow_d_r)),
        .src_fall (sel ? (~fast_s & fast_d_r) : (~slow_s & slow_d_r)),
        .div      (dv),
        .in_fall  (in_fall[g]),
        .in_rise  (in_rise[g])
      );
    end
  endgenerate

  // Underflow on the falling input edge while the count is zero
  assign uf16   = width_mode_sel_r && in_fall[0] && count_r[0] == 8'h00
                  && count_r[1] == 8'h00;
  assign unf[0] = !width_mode_sel_r && in_fall[0] && count_r[0] == 8'h00;
  assign unf[1] = width_mode_sel_r ? uf16
                  : (in_fall[1] && count_r[1] == 8'h00);

  // Bus write decode
  assign wr_go   = aw_have_r && w_have_r && !s_axi_bvalid;
  assign ctrl_wr = wr_go && awaddr_r == `DRT_OFF_CTRL && wstrb_ok_r;
  assign cfg_wr[0] = wr_go && awaddr_r == `DRT_OFF_CFG0;
  assign cfg_wr[1] = wr_go && awaddr_r == `DRT_OFF_CFG1;
  assign pset_wr[0] = ctrl_wr && wdata_r[`DRT_CTL_PRESET_CH0];
  assign pset_wr[1] = ctrl_wr && wdata_r[`DRT_CTL_PRESET_CH1] && !width_mode_sel_r;

  // Width select register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      width_mode_sel_r <= 1'b0;
    else if (ctrl_wr)
      width_mode_sel_r <= wdata_r[`DRT_CTL_WIDTH];
  end

  // Run bits: software sets, one-shot underflow clears, ch1 forced off in 16-bit
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      run_r <= 2'b00;
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (ctrl_wr)
          run_r[i] <= wdata_r[`DRT_CTL_RUN0 + i];
        if (i == 0 ? (uf16 || unf[0]) && !repeat_r[0] : unf[1] && !repeat_r[1]
            && !width_mode_sel_r)
          run_r[i] <= 1'b0;
      end
      if (width_mode_sel_r || (ctrl_wr && wdata_r[`DRT_CTL_WIDTH]))
        run_r[1] <= 1'b0;
    end
  end

  // Per-channel configuration: repeat, source, ratio, reload
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      repeat_r  <= 2'b00;
      src_sel_r <= 2'b00;
      for (int i = 0; i < 2; i++)
      begin
        div_r[i]    <= 2'b00;
        reload_r[i] <= `DRT_RESET_BYTE;
      end
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (cfg_wr[i])
        begin
          repeat_r[i]  <= wdata_r[`DRT_CFG_CONT];
          src_sel_r[i] <= wdata_r[`DRT_CFG_SRC];
          div_r[i]     <= wdata_r[`DRT_CFG_DIV_LO +: 2];
          reload_r[i]  <= wdata_r[`DRT_CFG_RLD_LO +: 8];
        end
      end
    end
  end

  // Counters: decrement on fall; pending reload lands at next rise, or at once if stopped
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count_r[0] <= `DRT_RESET_BYTE;
      count_r[1] <= `DRT_RESET_BYTE;
      pend_r     <= 2'b00;
    end
    else if (width_mode_sel_r)
    begin
      if (pset_wr[0])
      begin
        count_r[0] <= reload_r[0];
        count_r[1] <= reload_r[1];
        pend_r     <= 2'b00;
      end
      else if (pend_r[0] && (in_rise[0] || !run_r[0]))
      begin
        count_r[0] <= reload_r[0];
        count_r[1] <= reload_r[1];
        pend_r     <= 2'b00;
      end
      else if (in_fall[0] && !pend_r[0])
      begin
        {count_r[1], count_r[0]} <= {count_r[1], count_r[0]} - 16'h0001;
        if (uf16)
          pend_r[0] <= 1'b1;
      end
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (pset_wr[i])
        begin
          count_r[i] <= reload_r[i];
          pend_r[i]  <= 1'b0;
        end
        else if (pend_r[i] && (in_rise[i] || !run_r[i]))
        begin
          count_r[i] <= reload_r[i];
          pend_r[i]  <= 1'b0;
        end
        else if (in_fall[i] && !pend_r[i])
        begin
          count_r[i] <= count_r[i] - 8'h01;
          if (unf[i])
            pend_r[i] <= 1'b1;
        end
      end
    end
  end

  // Underflow pulses, halved output and serial clock
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      underflow_flag_ch0   <= 1'b0;
      underflow_flag_ch1   <= 1'b0;
      halved_underflow_out <= 1'b0;
      serial_clk_pulse     <= 1'b0;
    end
    else
    begin
      underflow_flag_ch0 <= unf[0] && !pend_r[0];
      underflow_flag_ch1 <= unf[1] && !pend_r[width_mode_sel_r ? 0 : 1];
      serial_clk_pulse   <= unf[1] && !pend_r[width_mode_sel_r ? 0 : 1];
      if (unf[1] && !pend_r[width_mode_sel_r ? 0 : 1])
        halved_underflow_out <= ~halved_underflow_out;
    end
  end

  // AXI write address and data capture, either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      awaddr_r  <= 4'h0;
      wdata_r   <= 32'h0000_0000;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      else if (wr_go)
        aw_have_r <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_ok_r <= s_axi_wstrb != 4'h0;  // Strobes held only with the data beat
      end
      else if (wr_go)
        w_have_r <= 1'b0;
    end
  end

  // Ready flags and write response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `DRT_RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_have_r && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready  <= !w_have_r && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_r == `DRT_OFF_STAT || awaddr_r[1:0] != 2'b00)
                        ? `DRT_RESP_SLVERR : `DRT_RESP_OKAY;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Read mux; count buffers read live
  always_comb
  begin
    rd_nxt = 32'h0000_0000;
    rd_ok  = 1'b1;
    unique case (s_axi_araddr)
      `DRT_OFF_CTRL: rd_nxt = {27'h0, width_mode_sel_r, 2'b00, run_r};
      `DRT_OFF_CFG0: rd_nxt = {16'h0, reload_r[0], 4'h0, div_r[0], src_sel_r[0], repeat_r[0]};
      `DRT_OFF_CFG1: rd_nxt = {16'h0, reload_r[1], 4'h0, div_r[1], src_sel_r[1], repeat_r[1]};
      `DRT_OFF_STAT: rd_nxt = {16'h0, count_r[1], count_r[0]};
      default:       rd_ok  = 1'b0;
    endcase
  end

  // Read channel: one read at a time
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `DRT_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_nxt;
        s_axi_rresp  <= rd_ok ? `DRT_RESP_OKAY : `DRT_RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- verif/drt_top_asserts.sv ----
// Purpose: Port-level checker for drt_top
// Assumes: One clock domain, bound to drt_top
// Notes:   Width mode is followed from finished control writes
`timescale 1ns/100ps
`default_nettype none
module drt_asserts
  import drt_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [3:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        underflow_flag_ch0,
  input wire logic        underflow_flag_ch1,
  input wire logic        halved_underflow_out,
  input wire logic        serial_clk_pulse
);
  logic [3:0] addr_r;
  logic       bit_r;
  logic       wide_r;
  // Follow the width select through completed writes to offset zero
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      addr_r <= 4'h0;
      bit_r  <= 1'b0;
      wide_r <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready) addr_r <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) bit_r <= s_axi_wdata[4];
      if (s_axi_bvalid && s_axi_bready && addr_r == 4'h0) wide_r <= bit_r;
    end
  end
  default clocking dcb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Address and data taken on one edge
  sequence both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Three cycles without a ch1 underflow
  sequence ch1_idle;
    !underflow_flag_ch1 [*3];
  endsequence
  AST_FLAG0_PULSE: assert property (
    underflow_flag_ch0 |=> !underflow_flag_ch0) else $error("ch0 pulse too long");
  AST_FLAG1_PULSE: assert property (
    underflow_flag_ch1 |=> !underflow_flag_ch1) else $error("ch1 pulse too long");
  AST_SERIAL_SAME: assert property (
    serial_clk_pulse == underflow_flag_ch1) else $error("serial pulse off ch1 timing");
  AST_HALVED_FLIP: assert property (
    underflow_flag_ch1 |-> ##[0:1] (halved_underflow_out != $past(halved_underflow_out)))
    else $error("halved output missed a toggle");
  AST_HALVED_QUIET: assert property (
    ch1_idle |-> $stable(halved_underflow_out)) else $error("halved output stray toggle");
  AST_WIDE_NO_CH0: assert property (
    wide_r && $past(wide_r, 4) |-> !underflow_flag_ch0) else $error("ch0 flag in 16-bit mode");
  AST_READ_ANSWER: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  AST_WRITE_ANSWER: assert property (
    both_taken |-> ##[1:3] s_axi_bvalid) else $error("write answer late");
  AST_RESET_QUIET: assert property (
    disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !underflow_flag_ch0
    && !underflow_flag_ch1) else $error("output active after reset");
endmodule
bind drt_top drt_asserts u_chk
(
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .underflow_flag_ch0, .underflow_flag_ch1,
  .halved_underflow_out, .serial_clk_pulse
);
`default_nettype wire

// ---- verif/testbench.sv ----
// Purpose: Self-checking bench for drt_top
// Assumes: Slow source 16 cycles a period, fast source 6
// Notes:   Expected bus answers wait in queues for the monitor
`timescale 1ns/100ps
`default_nettype none
module testbench
  import drt_pkg::*;
;
  logic        aclk, aresetn, slow_osc, fast_osc, s_axi_awvalid, s_axi_awready;
  logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, serial_clk_pulse;
  logic        underflow_flag_ch0, underflow_flag_ch1, halved_underflow_out;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, rng, bq[$], rq[$];
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          fails, compares, cyc, n0, n1, t0, t1, p0, p1, s;
  logic [31:0] cfgs[5] = '{32'h501, 32'h505, 32'h509, 32'h50d, 32'h503};
  logic [31:0] gaps[5] = '{32'h60, 32'h180, 32'h600, 32'h1800, 32'h24};
  drt_top uut
  (
    .aclk, .aresetn, .slow_osc, .fast_osc, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .underflow_flag_ch0, .underflow_flag_ch1,
    .halved_underflow_out, .serial_clk_pulse
  );
  // Free-running clock
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Compare and count
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Verdict and end of run
  task automatic summarize();
    if (fails == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Xorshift step
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction
  // Bus write, response noted for the monitor
  task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    bit ad = 1'b0;
    bit wd = 1'b0;
    bq.push_back({30'h0, r});
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (!(ad && wd))
    begin
      @(posedge aclk);
      ad = ad | s_axi_awready;
      wd = wd | s_axi_wready;
      if (ad) s_axi_awvalid <= 1'b0;
      if (wd) s_axi_wvalid <= 1'b0;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  // Bus read, data noted for the monitor
  task automatic axr(input logic [3:0] a, input logic [31:0] e);
    rq.push_back(e);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask
  // Wait for k more underflow pulses of a channel
  task automatic pulses(input int ch, input int k);
    int b;
    b = ch ? n1 : n0;
    while ((ch ? n1 : n0) < b + k) @(posedge aclk);
  endtask
  // Sources, pulse timing, answer checks and the hang limit
  always @(posedge aclk)
  begin
    cyc++;
    slow_osc <= (cyc % 16) < 8;
    fast_osc <= (cyc % 6) < 3;  // Fast source: 6-cycle period, high for 3
    if (underflow_flag_ch0 === 1'b1)
    begin
      p0 = t0;
      t0 = cyc;
      n0++;
    end
    if (underflow_flag_ch1 === 1'b1)
    begin
      p1 = t1;
      t1 = cyc;
      n1++;
    end
    if (s_axi_bvalid === 1'b1 && s_axi_bready)
      check("bresp", {30'h0, s_axi_bresp}, bq.pop_front());
    if (s_axi_rvalid === 1'b1 && s_axi_rready)
    begin
      check("rdata", s_axi_rdata, rq.pop_front());
      check("rresp", {30'h0, s_axi_rresp}, 32'h0);
    end
    if (cyc > 60000)
    begin
      fails++;
      summarize();
    end
  end
  // Main sequence
  initial
  begin
    rng = 32'h27;
    {aresetn, s_axi_awvalid, s_axi_wvalid} = 3'h0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 11'h000;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    axr(4'h0, 32'h0);
    axr(4'h4, 32'h0);
    axr(4'h8, 32'h0);
    axr(4'hc, 32'h0);
    axw(4'hc, 32'hffff, 2'h2);
    repeat (3)
    begin
      rng = xs(rng);
      axw(4'h4, {16'h0, rng[7:0], 4'h0, rng[11:8]}, 2'h0);
      axw(4'h8, {16'h0, rng[23:16], 8'h00}, 2'h0);
      axw(4'h0, 32'hc, 2'h0);
      axr(4'h4, {16'h0, rng[7:0], 4'h0, rng[11:8]});
      axr(4'hc, {16'h0, rng[23:16], rng[7:0]});
    end
    axw(4'h8, 32'h301, 2'h0);
    foreach (cfgs[i])
    begin
      axw(4'h4, cfgs[i], 2'h0); // Reload kept at 5 while running
      if (i == 0) axw(4'h0, 32'hf, 2'h0);
      pulses(0, 3);
      check("ch0 period", 32'(t0 - p0), gaps[i]);
    end
    pulses(1, 2);
    check("ch1 period", 32'(t1 - p1), 32'h40);
    axw(4'h0, 32'h0, 2'h0);
    repeat (2) @(posedge aclk);
    s = n0 + n1;
    repeat (300) @(posedge aclk);
    check("stopped pulses", 32'(n0 + n1), 32'(s));
    axw(4'h4, 32'h200, 2'h0);
    axw(4'h0, 32'hd, 2'h0);
    for (int k = 0; k < 2; k++)
    begin
      if (k == 1) axw(4'h0, 32'h1, 2'h0);
      pulses(0, 1);
      repeat (40) @(posedge aclk);
      axr(4'h0, 32'h0);
      axr(4'hc, 32'h302);
    end
    axw(4'h4, 32'h1, 2'h0);
    axw(4'h8, 32'h10f, 2'h0);
    axw(4'h0, 32'h1f, 2'h0);
    axr(4'h0, 32'h11);
    s = n0;
    pulses(1, 3);
    check("16-bit period", 32'(t1 - p1), 32'h1010);
    check("ch0 pulses in 16-bit mode", 32'(n0), 32'(s));
    summarize();
  end
endmodule
`default_nettype wire
